// ===== design/spr_pkg.sv
// Purpose: shared constants for the two-frame serial readback link
// Assumes: link clock is slow against core_clk; the host makes it, the device samples it
// Notes:   frame is payload, register index, chip code, all msb first
package spr_pkg;
  // frame layout
  localparam int FRAME_BITS   = 32;
  localparam int PAYLOAD_BITS = 24;
  localparam int IDX_BITS     = 5;
  localparam int CHIP_BITS    = 3;
  localparam int IDX_LSB      = 3;
  localparam int PAYLOAD_LSB  = 8;
  localparam int CODE_FIRST   = 30;   // rising edge that takes the first chip bit
  localparam logic [5:0] FRAME_COUNT = 6'h20;
  localparam logic [5:0] CODE_EDGE0  = 6'h1e;
  localparam logic [5:0] CODE_EDGE1  = 6'h1f;
  localparam logic [2:0] CHIP_CODE   = 3'h0;
  localparam logic [4:0] PTR_REG     = 5'h00;
  localparam logic [2:0] MASK_NONE   = 3'h0;
  localparam logic [2:0] MASK_ONE    = 3'h1;
  localparam logic [2:0] MASK_TWO    = 3'h3;
  localparam logic [2:0] MASK_ALL    = 3'h7;
  // arbitrary identity value, not that of any real part
  localparam logic [23:0] CHIP_ID_DEFAULT = 24'h5a0c01;
  // timing
  localparam int CORE_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int HALF_CYCLES    = LINK_PERIOD_NS / CORE_PERIOD_NS / 2;
  // host command registers (word index on the plain port)
  localparam logic [1:0] HOST_CMD    = 2'h0;
  localparam logic [1:0] HOST_DATA   = 2'h1;
  localparam logic [1:0] HOST_STATUS = 2'h2;
  localparam int CMD_GO    = 0;
  localparam int CMD_READ  = 1;
  localparam int CMD_ADDR  = 2;
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;
endpackage

// ===== design/spr_link_if.sv
// Purpose: three-wire link plus shared lock detect / serial out pin
// Assumes: pin has a pull-up when nobody drives it
// Notes:   the wire level is resolved here from the enable
`timescale 1ns/1ns
interface spr_link_if;
  logic serialClock;
  logic serialInputLine;
  logic frameLatchEnable;
  logic lockDetectSerialOutPinOut;
  logic lockDetectSerialOutPinOe;
  logic lockDetectSerialOutPinLevel;

  // pull-up when the device releases the pin
  assign lockDetectSerialOutPinLevel =
    lockDetectSerialOutPinOe ? lockDetectSerialOutPinOut : 1'b1;

  modport device (
    input  serialClock,
    input  serialInputLine,
    input  frameLatchEnable,
    output lockDetectSerialOutPinOut,
    output lockDetectSerialOutPinOe
  );
  modport host (
    output serialClock,
    output serialInputLine,
    output frameLatchEnable,
    input  lockDetectSerialOutPinLevel
  );
endinterface

// ===== design/spr_device.sv
// Purpose: device end: frame capture, read pointer, readback on shared pin
// Assumes: all link inputs are asynchronous and pass two flip-flops
// Notes:   register 0 reads the identity word; writes to it load the pointer
// Functional notes
// - pin driven during frames once addressed
// - each frame shows register selected by pointer
// - unchanged pointer repeats same data every frame
// - read is pointer frame then data frame
// - sample payload, index, chip code on rises
// - host sends index zero for pointer frame
// - host sends chip code zero
// - host raises latch after 32nd rise
// - capture frame on latch rising edge
// - host drops latch after capture
// - host repeats pointer frame when idle; this host sends nothing when idle and repeats it only as a read's second frame
// - readback frame still samples 32 input bits
// - frame switches pin to data, hides lock
// - latch ends frame, lock detect returns
// - driver enabled only when chip code matches; a latch before any chip code bit also enables it
// - register 0 bits 4:0 are write-only pointer
`timescale 1ns/1ns
module spr_device #(
  parameter logic [23:0] CHIP_ID = spr_pkg::CHIP_ID_DEFAULT
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // link
  spr_link_if.device                         link,
  // user side
  input  wire logic                          lockDetectOutput,
  output logic                               regWrStb,
  output logic [spr_pkg::IDX_BITS-1:0]       regWrAddr,
  output logic [spr_pkg::PAYLOAD_BITS-1:0]   regWrData,
  output logic [spr_pkg::IDX_BITS-1:0]       readPointer,
  output logic                               serialOutputMode,
  output logic                               driverEnable
);
  import spr_pkg::*;

  logic [2:0]              clkSync;
  logic [1:0]              dinSync;
  logic [2:0]              latSync;
  logic                    clkRise;
  logic                    clkFall;
  logic                    latRise;
  logic [5:0]              bitCount;
  logic [FRAME_BITS-1:0]   inShift;
  logic [FRAME_BITS-1:0]   outShift;
  logic [PAYLOAD_BITS-1:0] mem [1:(1<<IDX_BITS)-1];
  logic [PAYLOAD_BITS-1:0] readWord;
  logic [PAYLOAD_BITS-1:0] payload;
  logic [IDX_BITS-1:0]     frameIdx;
  logic [CHIP_BITS-1:0]    chipMask;
  logic                    addressed;
  logic                    frameOk;
  logic                    pinOut;

  // two-stage synchronisers; clock and latch keep a third stage as edge history
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clkSync <= 3'h0;
      dinSync <= 2'h0;
      latSync <= 3'h0;
    end else begin
      clkSync <= {clkSync[1:0], link.serialClock};
      dinSync <= {dinSync[0], link.serialInputLine};
      latSync <= {latSync[1:0], link.frameLatchEnable};
    end
  end

  // edges from stages 2 and 3; stage 1 only settles and is never read
  // the link is slow against core_clk, so the two-cycle lag costs nothing
  assign clkRise = clkSync[1] & ~clkSync[2];
  assign clkFall = ~clkSync[1] & clkSync[2];
  assign latRise = latSync[1] & ~latSync[2];

  // frame fields out of the single input shift register
  assign payload  = inShift[FRAME_BITS-1:PAYLOAD_LSB];
  assign frameIdx = inShift[PAYLOAD_LSB-1:IDX_LSB];
  // a frame counts only with all 32 bits in and our chip code last
  assign frameOk  = (bitCount == FRAME_COUNT) && (inShift[CHIP_BITS-1:0] == CHIP_CODE);

  // rising-edge counter; extra edges past a full frame are ignored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bitCount <= 6'h0;
    end else if (latRise) begin
      bitCount <= 6'h0;
    end else if (clkRise && !latSync[1] && bitCount != FRAME_COUNT) begin
      bitCount <= 6'(bitCount + 6'h1);
    end
  end

  // input bits shift in msb first on each counted rising edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inShift <= '0;
    end else if (clkRise && !latSync[1] && bitCount != FRAME_COUNT) begin
      inShift <= {inShift[FRAME_BITS-2:0], dinSync[1]};
    end
  end

  // word shown in the next frame; pointer 0 has no readable pointer, only the id
  assign readWord = (readPointer == PTR_REG) ? CHIP_ID : mem[readPointer];

  // output word reloads while idle, so a new pointer shows from the next frame
  // limitation: bit 1 reaches the pin only after the first rise, hosts sample late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outShift <= '0;
    end else if (bitCount == 6'h0 && !clkRise) begin
      outShift <= {readWord, {(FRAME_BITS-PAYLOAD_BITS){1'b0}}};
    end else if (clkFall && bitCount != 6'h0) begin
      outShift <= {outShift[FRAME_BITS-2:0], 1'b0};
    end
  end

  // pointer moves only at latch rise of a complete addressed frame
  // short frames and foreign chip codes leave the pointer alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readPointer <= PTR_REG;
    end else if (latRise && frameOk && frameIdx == PTR_REG) begin
      readPointer <= payload[IDX_BITS-1:0];
    end
  end

  // register file for indexes above 0; no documented defaults, so zero
  // index 0 is never stored: a write there only moves the pointer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 1; i < (1 << IDX_BITS); i++) begin
        mem[i] <= '0;
      end
    end else if (latRise && frameOk && frameIdx != PTR_REG) begin
      mem[frameIdx] <= payload;
    end
  end

  // write notice to the user side, one cycle pulse with held data
  // pointer frames are reported too, so the user side sees every capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regWrStb  <= 1'b0;
      regWrAddr <= '0;
      regWrData <= '0;
    end else begin
      regWrStb <= latRise && frameOk;
      if (latRise && frameOk) begin
        regWrAddr <= frameIdx;
        regWrData <= payload;
      end
    end
  end

  // chip-code bits seen so far; a short frame with no code bits counts as ours
  always_comb begin
    if (bitCount == FRAME_COUNT) begin
      chipMask = MASK_ALL;
    end else if (bitCount == CODE_EDGE1) begin
      chipMask = MASK_TWO;
    end else if (bitCount == CODE_EDGE0) begin
      chipMask = MASK_ONE;
    end else begin
      chipMask = MASK_NONE;
    end
  end
  assign addressed = ((inShift[CHIP_BITS-1:0] & chipMask) == CHIP_CODE);

  // driver stays released after reset so the pin can be shared until addressed
  // once on, it stays on between frames so lock detect remains visible
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      driverEnable <= 1'b0;
    end else if (latRise) begin
      driverEnable <= addressed;
    end
  end

  // serial mode while a frame is in progress
  // drops on the latch rise, together with the pin's return to lock detect
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serialOutputMode <= 1'b0;
    end else begin
      serialOutputMode <= (bitCount != 6'h0) && !latRise;
    end
  end

  // pin data: readback bit in a frame, lock detect otherwise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinOut <= 1'b0;
    end else if (bitCount != 6'h0 && !latRise) begin
      pinOut <= outShift[FRAME_BITS-1];
    end else begin
      pinOut <= lockDetectOutput;
    end
  end

  // pin data and enable both come straight from flops, so the shared
  // wire never sees a combinational glitch
  assign link.lockDetectSerialOutPinOut = pinOut;
  assign link.lockDetectSerialOutPinOe  = driverEnable;
endmodule

// ===== design/spr_host.sv
// Purpose: host end: runs write frames and two-frame reads on the link
// Assumes: software uses the plain port; read data one cycle after strobe
// Notes:   link clock is divided from core_clk and idles low
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ns
module spr_host #(
  parameter int HALF = spr_pkg::HALF_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // link
  spr_link_if.host         link,
  // register port
  input  wire logic [1:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [31:0] rdData
);
  import spr_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_LATCH, S_GAP} spr_state_t;

  spr_state_t              state;
  logic [3:0]              halfCnt;
  logic [5:0]              bitIdx;
  logic [FRAME_BITS-1:0]   txWord;
  logic [FRAME_BITS-1:0]   frameWord;
  logic [FRAME_BITS-1:0]   rxShift;
  logic [PAYLOAD_BITS-1:0] dataReg;
  logic [PAYLOAD_BITS-1:0] result;
  logic [IDX_BITS-1:0]     target;
  logic                    isRead;
  logic                    second;
  logic                    done;
  logic                    finish;
  logic                    halfEnd;
  logic [1:0]              pinSync;
  logic                    start;

  assign start   = wrStb && addr == HOST_CMD && wrData[CMD_GO] && state == S_IDLE;
  assign halfEnd = (halfCnt == 4'(HALF - 1));
  assign finish  = (state == S_GAP) && halfEnd && !(isRead && !second);

  // pointer frame for reads (sent twice), data frame for writes
  assign frameWord = isRead ? {{(PAYLOAD_BITS-IDX_BITS){1'b0}}, target, PTR_REG, CHIP_CODE}
                            : {dataReg, target, CHIP_CODE};

  // readback pin is asynchronous to us
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinSync <= 2'h0;
    end else begin
      pinSync <= {pinSync[0], link.lockDetectSerialOutPinLevel};
    end
  end

  // command and data registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dataReg <= '0;
      target  <= '0;
      isRead  <= 1'b0;
    end else if (start) begin
      isRead <= wrData[CMD_READ];
      target <= wrData[CMD_ADDR +: IDX_BITS];
    end else if (wrStb && addr == HOST_DATA && state == S_IDLE) begin
      dataReg <= wrData[PAYLOAD_BITS-1:0];
    end
  end

  // frame sequencer; each bit is a low half then a high half
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state   <= S_IDLE;
      halfCnt <= 4'h0;
      bitIdx  <= 6'h0;
      second  <= 1'b0;
      txWord  <= '0;
      rxShift <= '0;
    end else begin
      halfCnt <= halfEnd ? 4'h0 : 4'(halfCnt + 4'h1);
      unique case (state)
        S_IDLE: begin
          halfCnt <= 4'h0;
          if (start) begin
            state  <= S_LOW;
            bitIdx <= 6'h0;
            second <= 1'b0;
          end
        end
        S_LOW: begin
          if (halfCnt == 4'h0 && bitIdx == 6'h0) begin
            txWord <= frameWord;
          end
          if (halfEnd) begin
            state <= S_HIGH;
            // previous bit: the device shows bit 1 only after our first rise,
            // so each bit is taken just before the next rise, past both syncs
            if (bitIdx != 6'h0) begin
              rxShift <= {rxShift[FRAME_BITS-2:0], pinSync[1]};
            end
          end
        end
        S_HIGH: begin
          if (halfEnd) begin
            txWord  <= {txWord[FRAME_BITS-2:0], 1'b0};
            bitIdx  <= 6'(bitIdx + 6'h1);
            state   <= (bitIdx == 6'(FRAME_BITS - 1)) ? S_LATCH : S_LOW;
          end
        end
        S_LATCH: begin
          if (halfEnd) begin
            // last bit, still on the pin until the device sees the latch
            rxShift <= {rxShift[FRAME_BITS-2:0], pinSync[1]};
            state <= S_GAP;
          end
        end
        S_GAP: begin
          if (halfEnd) begin
            bitIdx <= 6'h0;
            if (isRead && !second) begin
              second <= 1'b1;
              state  <= S_LOW;
            end else begin
              state <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // link pins straight from state flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.serialClock      <= 1'b0;
      link.serialInputLine  <= 1'b0;
      link.frameLatchEnable <= 1'b0;
    end else begin
      link.serialClock      <= (state == S_HIGH);
      link.serialInputLine  <= (state == S_LOW || state == S_HIGH) ? txWord[FRAME_BITS-1] : 1'b0;
      link.frameLatchEnable <= (state == S_LATCH);
    end
  end

  // result capture and sticky done; a finish beats a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result <= '0;
      done   <= 1'b0;
    end else begin
      if (finish && isRead) begin
        result <= rxShift[FRAME_BITS-1:PAYLOAD_LSB];
      end
      if (finish) begin
        done <= 1'b1;
      end else if (wrStb && addr == HOST_STATUS && wrData[ST_DONE]) begin
        done <= 1'b0;
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdStb) begin
      unique case (addr)
        HOST_DATA:   rdData <= {8'h00, result};
        HOST_STATUS: rdData <= {30'h0, done, state != S_IDLE};
        default:     rdData <= '0;
      endcase
    end else begin
      rdData <= '0;
    end
  end
endmodule

// ===== sim/spr_link_asserts.sv
// Purpose: protocol checks on the link joining host and device
// Assumes: link is slow against core_clk, four core cycles a half
// Notes:   helper logic counts link rises in each frame
`timescale 1ns/1ns
module spr_link_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link
  input wire logic serialClock,
  input wire logic serialInputLine,
  input wire logic frameLatchEnable,
  input wire logic lockDetectSerialOutPinOut,
  input wire logic lockDetectSerialOutPinOe,
  input wire logic lockDetectSerialOutPinLevel
);
  import spr_pkg::*;
  logic [5:0] riseCount;
  logic       lastClk;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // rises since the last latch; the latch clears it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      riseCount <= 6'h00;
      lastClk   <= 1'b0;
    end else begin
      lastClk <= serialClock;
      if (frameLatchEnable) begin
        riseCount <= 6'h00;
      end else if (serialClock && !lastClk) begin
        riseCount <= riseCount + 6'h01;
      end
    end
  end
  property p_idle_in_latch;
    frameLatchEnable |-> !serialClock;
  endproperty
  a_idle_in_latch: assert property (p_idle_in_latch)
    else $error("link clock high during latch");
  property p_latch_pulse;
    $rose(frameLatchEnable) |-> frameLatchEnable[*4] ##[1:20] !frameLatchEnable;
  endproperty
  a_latch_pulse: assert property (p_latch_pulse)
    else $error("latch pulse length wrong");
  property p_data_on_fall;
    $changed(serialInputLine) |-> !serialClock;
  endproperty
  a_data_on_fall: assert property (p_data_on_fall)
    else $error("data changed while link clock high");
  property p_clock_high;
    $rose(serialClock) |-> serialClock[*4] ##1 !serialClock;
  endproperty
  a_clock_high: assert property (p_clock_high)
    else $error("link clock high half wrong");
  property p_code_zero;
    $rose(serialClock) && riseCount >= 6'h1d |-> !serialInputLine;
  endproperty
  a_code_zero: assert property (p_code_zero)
    else $error("chip code bit not zero");
  property p_frame_len;
    $rose(frameLatchEnable) |-> riseCount == FRAME_COUNT;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame not 32 rises");
  property p_driver_on;
    $fell(frameLatchEnable) |-> ##4 lockDetectSerialOutPinOe[*4];
  endproperty
  a_driver_on: assert property (p_driver_on)
    else $error("driver off after addressed frame");
  property p_tail_zero;
    $fell(serialClock) && riseCount > 6'h18 && lockDetectSerialOutPinOe
      |-> !lockDetectSerialOutPinLevel;
  endproperty
  a_tail_zero: assert property (p_tail_zero)
    else $error("pin bits 25 to 32 not zero");
  c_latch: cover property ($rose(frameLatchEnable));
  c_driver: cover property ($rose(lockDetectSerialOutPinOe));
  c_full: cover property ($fell(serialClock) && riseCount == 6'h20);
endmodule

// ===== sim/serial_port_two_cycle_readback_bench.sv
// Purpose: host and device joined on one link, driven from the register port
// Assumes: a second device on its own link takes hand-made frames
// Notes:   expectations come from the frame layout only
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t mismatch %h %h", $time, (a), (b)); end end
module serial_port_two_cycle_readback_bench;
  import spr_pkg::*;
  // arbitrary identity value
  localparam logic [23:0] ID = 24'h3c6a21;
  logic        core_clk, rst, wrStb, rdStb, lock;
  logic [1:0]  addr;
  logic [31:0] wrData, rdData, inBits, pinBits, v;
  logic        regWrStb, regWrStb2, mode, drv2, sckLast;
  logic [4:0]  regWrAddr, regWrAddr2, readPointer;
  logic [23:0] regWrData;
  int          bad_count, check_count, stb, stb2;
  logic [4:0]  rdAddr [3] = '{5'h05, 5'h05, 5'h00};
  logic [23:0] rdExp [3] = '{24'ha5c3e1, 24'ha5c3e1, ID};
  spr_link_if link();
  spr_link_if link2();
  spr_host spr_host_i (.core_clk(core_clk), .rst(rst), .link(link), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
  spr_device #(.CHIP_ID(ID)) spr_device_i (.core_clk(core_clk), .rst(rst),
    .link(link), .lockDetectOutput(lock), .regWrStb(regWrStb), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .readPointer(readPointer), .serialOutputMode(mode),
    .driverEnable());
  spr_device spr_device_fault_i (.core_clk(core_clk), .rst(rst), .link(link2),
    .lockDetectOutput(1'b1), .regWrStb(regWrStb2), .regWrAddr(regWrAddr2),
    .regWrData(), .readPointer(), .serialOutputMode(), .driverEnable(drv2));
  spr_link_asserts spr_link_asserts_i (.core_clk(core_clk), .rst(rst),
    .serialClock(link.serialClock), .serialInputLine(link.serialInputLine),
    .frameLatchEnable(link.frameLatchEnable),
    .lockDetectSerialOutPinOut(link.lockDetectSerialOutPinOut),
    .lockDetectSerialOutPinOe(link.lockDetectSerialOutPinOe),
    .lockDetectSerialOutPinLevel(link.lockDetectSerialOutPinLevel));
  // clock source
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // wire monitors: bits as the device takes them, pin bits one cycle after each fall
  // the pin may move on the very edge that drops the link clock, so wait a cycle
  always @(posedge link.serialClock) inBits <= {inBits[30:0], link.serialInputLine};
  always @(posedge core_clk) begin
    sckLast <= link.serialClock;
    if (sckLast === 1'b1 && link.serialClock === 1'b0) begin
      pinBits <= {pinBits[30:0], link.lockDetectSerialOutPinLevel};
    end
  end
  // capture strobes are one cycle wide, so count them
  always @(posedge core_clk) begin
    if (regWrStb === 1'b1) stb++;
    if (regWrStb2 === 1'b1) stb2++;
  end
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge core_clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge core_clk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask
  // issue a command and poll until done; poll is bounded
  task automatic run(input logic [31:0] c);
    logic [31:0] s;
    int n;
    s = 32'h0;
    n = 0;
    wr(HOST_CMD, c);
    while (s[ST_DONE] !== 1'b1 && n < 2000) begin
      rd(HOST_STATUS, s);
      n++;
    end
    `CHK(s[ST_DONE], 1'b1)
    wr(HOST_STATUS, 32'h2);
  endtask
  // hand-made frame on the second link, used to break the chip code
  task automatic frm(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      link2.serialInputLine <= w[i];
      repeat (4) @(posedge core_clk);
      link2.serialClock <= 1'b1;
      repeat (4) @(posedge core_clk);
      link2.serialClock <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    link2.frameLatchEnable <= 1'b1;
    repeat (8) @(posedge core_clk);
    link2.frameLatchEnable <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog: all frames need about 2700 cycles, allow over seven times that
  initial begin
    #2000000;
    bad_count++;
    close_out();
  end
  // main sequence
  initial begin
    {rst, wrStb, rdStb, addr, wrData, lock} = {1'b1, 36'h0, 1'b1};
    {link2.serialClock, link2.serialInputLine, link2.frameLatchEnable} = 3'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    wr(HOST_DATA, 32'h00a5c3e1);
    run(32'h15);
    `CHK(regWrAddr, 5'h05)
    `CHK(regWrData, 24'ha5c3e1)
    `CHK(inBits, 32'ha5c3e128)
    $display("test write done");
    for (int i = 0; i < 3; i++) begin
      run({25'h0, rdAddr[i], 2'h3});
      rd(HOST_DATA, v);
      `CHK(readPointer, rdAddr[i])
      `CHK(v[23:0], rdExp[i])
      `CHK(pinBits, {rdExp[i], 8'h00})
      `CHK(inBits, {19'h0, rdAddr[i], 8'h00})
    end
    `CHK(stb, 7)
    $display("test reads done");
    run(32'h1d);
    `CHK(pinBits, {ID, 8'h00})
    `CHK(regWrAddr, 5'h07)
    lock <= 1'b0;
    repeat (5) @(posedge core_clk);
    `CHK(link.lockDetectSerialOutPinLevel, 1'b0)
    `CHK(mode, 1'b0)
    lock <= 1'b1;
    repeat (5) @(posedge core_clk);
    `CHK(link.lockDetectSerialOutPinLevel, 1'b1)
    $display("test lock done");
    frm(32'h000abc18);
    `CHK(stb2, 1)
    `CHK(regWrAddr2, 5'h03)
    `CHK(drv2, 1'b1)
    frm(32'h000abc1d);
    `CHK(stb2, 1)
    `CHK(drv2, 1'b0)
    $display("test chip code done");
    close_out();
  end
endmodule
